// ===== rtl/msc_consts.svh
// Purpose: Shared constants for the memory sideband control link.
// Assumes: Single bus clock of 25 MHz.
// Notes: Test vector type codes are {request_a, request_b}.
`ifndef MSC_CONSTS_SVH
`define MSC_CONSTS_SVH
`define MSC_VEC_IDLE 2'h0
`define MSC_VEC_ADDR 2'h1
`define MSC_VEC_WRITE 2'h2
`define MSC_VEC_READ 2'h3
`define MSC_ACCESS_CYCLES 4'h3
`define MSC_REFRESH_ENTRY_CYCLES 4'h4
`define MSC_DRAIN_CYCLES 4'h2
`endif

// ===== rtl/msc_device.sv
// Purpose: Controller end of the sideband link: test port, bus arbitration,
//    DLL calibration and self-refresh handshakes.
// Assumes: Partner inputs are logic on the same bus clock, so no synchronisers.
// Notes: Memory engines stand outside; user ports stand in for them.
// Operation
// - Test mode select enters test mode
// - Request A asks for test entry
// - Requests A and B encode vector type
// - Acknowledge high grants bus, completes access
// - Tester holds vector while acknowledge low
// - Control logic timed on rising bus clock; read captures and delayed launch use other clocks
// - Inverted clock may capture read data
// - DDR pads timed from double clock
// - Inverted double clock drives negedge flops
// - Delayed clock launches commands when selected
// - Bus reset active low resets logic
// - Power-on reset separate, active low
// - Request high while bus needed
// - Drive memory only while granted; MEMORY_DRIVE stays high through the drain after grant drops
// - Backoff makes device give up bus
`timescale 1ns/1ps
`include "msc_consts.svh"
module msc_device (
   // Clocks
   input wire logic CLOCK,
   input wire logic BUS_CLOCK_INVERTED,
   input wire logic DOUBLE_RATE_CLOCK,
   input wire logic DOUBLE_RATE_CLOCK_INVERTED,
   input wire logic DELAYED_BUS_CLOCK,
   // Resets and enable
   input wire logic RESET_N,
   input wire logic POWER_ON_RESET_N,
   input wire logic CLOCK_ENABLE,
   // Link
   msc_link_if.device LINK,
   // User side
   input wire logic ACCESS_NEEDED,
   input wire logic CALIBRATE_START,
   input wire logic COMMAND_DELAYED_MODE,
   input wire logic DDR_ENABLE,
   input wire logic [1:0] READ_DATA_PIN,
   output logic MEMORY_DRIVE,
   output logic IN_TEST_MODE,
   output msc_pkg::msc_vec_t TEST_VECTOR_TYPE,
   output logic IN_SELF_REFRESH,
   output logic CALIBRATED,
   output logic COMMAND_LAUNCH,
   output logic [1:0] DDR_CAPTURE,
   output logic SDR_CAPTURE
);
   import msc_pkg::*;

   msc_bus_state_t state;
   logic [3:0] count;
   logic [3:0] test_count;
   logic test_busy;
   logic test_armed;
   logic [3:0] sref_count;
   logic sref_wait;
   logic cal_pending;
   logic por_done;
   logic cmd_tick;
   logic ddr_rise;
   logic ddr_fall;
   logic capture_neg;

   // Power-on reset records that the part has powered up; no bus request is made before then
   always_ff @(posedge CLOCK or negedge POWER_ON_RESET_N) begin
      if (!POWER_ON_RESET_N) begin
         por_done <= 1'b0;
      end else if (CLOCK_ENABLE) begin
         por_done <= 1'b1;
      end
   end

   // Test port: entry, vector decode and access completion
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         IN_TEST_MODE <= 1'b0;
         LINK.test_acknowledge <= 1'b0;
         TEST_VECTOR_TYPE <= `MSC_VEC_IDLE;
         test_busy <= 1'b0;
         test_count <= 4'h0;
         test_armed <= 1'b0;
      end else if (CLOCK_ENABLE) begin
         if (!LINK.test_mode_select) begin
            IN_TEST_MODE <= 1'b0;
            LINK.test_acknowledge <= 1'b0;
            test_busy <= 1'b0;
            test_armed <= 1'b0;
         end else if (!IN_TEST_MODE) begin
            // Enter only once the external bus is free, so no access is torn
            if (LINK.test_request_a && state == MSC_IDLE) begin
               IN_TEST_MODE <= 1'b1;
               LINK.test_acknowledge <= 1'b1;
            end
         end else if (!test_busy) begin
            // A code counts only after an idle cycle, so a held vector is not taken twice
            if ({LINK.test_request_a, LINK.test_request_b} == `MSC_VEC_IDLE) begin
               test_armed <= 1'b1;
            end else if (test_armed) begin
               TEST_VECTOR_TYPE <= {LINK.test_request_a, LINK.test_request_b};
               LINK.test_acknowledge <= 1'b0;
               test_busy <= 1'b1;
               test_count <= `MSC_ACCESS_CYCLES;
               test_armed <= 1'b0;
            end
         end else if (test_count == 4'h1) begin
            LINK.test_acknowledge <= 1'b1;
            test_busy <= 1'b0;
         end else begin
            test_count <= test_count - 4'h1;
         end
      end
   end

   // External bus arbitration
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         state <= MSC_IDLE;
         count <= 4'h0;
         LINK.ext_bus_request <= 1'b0;
         MEMORY_DRIVE <= 1'b0;
      end else if (CLOCK_ENABLE) begin
         unique case (state)
            MSC_IDLE: begin
               if (ACCESS_NEEDED && !IN_TEST_MODE && !IN_SELF_REFRESH && por_done) begin
                  LINK.ext_bus_request <= 1'b1;
                  state <= MSC_WAIT_GRANT;
               end
            end
            MSC_WAIT_GRANT: begin
               if (LINK.ext_bus_grant && !LINK.ext_bus_backoff) begin
                  MEMORY_DRIVE <= 1'b1;
                  state <= MSC_OWN;
               end
            end
            MSC_OWN: begin
               // Grant lost or backoff: wind down before letting go
               if (LINK.ext_bus_backoff || !LINK.ext_bus_grant || !ACCESS_NEEDED) begin
                  count <= `MSC_DRAIN_CYCLES;
                  state <= MSC_DRAIN;
               end
            end
            MSC_DRAIN: begin
               if (count == 4'h1) begin
                  MEMORY_DRIVE <= 1'b0;
                  LINK.ext_bus_request <= 1'b0;
                  state <= MSC_RELEASE;
               end else begin
                  count <= count - 4'h1;
               end
            end
            MSC_RELEASE: begin
               // Wait for grant to drop before asking again
               if (!LINK.ext_bus_grant) begin
                  state <= MSC_IDLE;
               end
            end
            default: state <= MSC_IDLE;
         endcase
      end
   end

   // DLL calibration four-phase handshake
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         LINK.dll_calibration_request <= 1'b0;
         cal_pending <= 1'b0;
         CALIBRATED <= 1'b0;
      end else if (CLOCK_ENABLE) begin
         if (CALIBRATE_START) begin
            cal_pending <= 1'b1;
         end else if (cal_pending && !LINK.dll_calibration_request &&
                      !LINK.dll_calibration_acknowledge) begin
            cal_pending <= 1'b0;
         end
         if (!LINK.dll_calibration_request) begin
            if (cal_pending && !LINK.dll_calibration_acknowledge) begin
               LINK.dll_calibration_request <= 1'b1;
               CALIBRATED <= 1'b0;
            end
         end else if (LINK.dll_calibration_acknowledge) begin
            LINK.dll_calibration_request <= 1'b0;
            CALIBRATED <= 1'b1;
         end
      end
   end

   // Self-refresh: wait for the bus to be idle, then take entry time
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         IN_SELF_REFRESH <= 1'b0;
         LINK.self_refresh_acknowledge <= 1'b0;
         sref_wait <= 1'b0;
         sref_count <= 4'h0;
      end else if (CLOCK_ENABLE) begin
         if (LINK.self_refresh_request && !LINK.self_refresh_acknowledge) begin
            if (!sref_wait && state == MSC_IDLE) begin
               IN_SELF_REFRESH <= 1'b1;
               sref_wait <= 1'b1;
               sref_count <= `MSC_REFRESH_ENTRY_CYCLES;
            end else if (sref_wait && sref_count == 4'h1) begin
               LINK.self_refresh_acknowledge <= 1'b1;
            end else if (sref_wait) begin
               sref_count <= sref_count - 4'h1;
            end
         end else if (!LINK.self_refresh_request && LINK.self_refresh_acknowledge) begin
            LINK.self_refresh_acknowledge <= 1'b0;
            IN_SELF_REFRESH <= 1'b0;
            sref_wait <= 1'b0;
         end
      end
   end

   // Command launch on the delayed clock; the mode is a static strap
   always_ff @(posedge DELAYED_BUS_CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         cmd_tick <= 1'b0;
      end else if (CLOCK_ENABLE && COMMAND_DELAYED_MODE) begin
         cmd_tick <= MEMORY_DRIVE;
      end
   end

   // Normal launch uses the bus clock edge instead
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         COMMAND_LAUNCH <= 1'b0;
      end else if (CLOCK_ENABLE) begin
         COMMAND_LAUNCH <= COMMAND_DELAYED_MODE ? cmd_tick : MEMORY_DRIVE;
      end
   end

   // DDR pad capture: rising half on the double clock
   always_ff @(posedge DOUBLE_RATE_CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         ddr_rise <= 1'b0;
      end else if (CLOCK_ENABLE && DDR_ENABLE) begin
         ddr_rise <= READ_DATA_PIN[0];
      end
   end

   // Falling half: posedge of the inverted clock stands for its negedge
   always_ff @(posedge DOUBLE_RATE_CLOCK_INVERTED or negedge RESET_N) begin
      if (!RESET_N) begin
         ddr_fall <= 1'b0;
      end else if (CLOCK_ENABLE && DDR_ENABLE) begin
         ddr_fall <= READ_DATA_PIN[1];
      end
   end

   // SDR read capture on the inverted bus clock gives half a cycle of margin
   always_ff @(posedge BUS_CLOCK_INVERTED or negedge RESET_N) begin
      if (!RESET_N) begin
         capture_neg <= 1'b0;
      end else if (CLOCK_ENABLE) begin
         capture_neg <= READ_DATA_PIN[0];
      end
   end

   // Retime captured data onto the bus clock
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         DDR_CAPTURE <= 2'h0;
         SDR_CAPTURE <= 1'b0;
      end else if (CLOCK_ENABLE) begin
         DDR_CAPTURE <= {ddr_fall, ddr_rise};
         SDR_CAPTURE <= capture_neg;
      end
   end
endmodule

// ===== rtl/msc_link_if.sv
// Purpose: Sideband wires between the controller and its partner logic.
// Assumes: All signals sampled on the rising bus clock.
// Notes: Partner holds the arbiter, tester, DLL and power manager.
`timescale 1ns/1ps
interface msc_link_if;
   logic test_mode_select;
   logic test_request_a;
   logic test_request_b;
   logic test_acknowledge;
   logic ext_bus_request;
   logic ext_bus_grant;
   logic ext_bus_backoff;
   logic dll_calibration_request;
   logic dll_calibration_acknowledge;
   logic self_refresh_request;
   logic self_refresh_acknowledge;
   modport device (
      input test_mode_select, test_request_a, test_request_b,
      output test_acknowledge,
      output ext_bus_request,
      input ext_bus_grant, ext_bus_backoff,
      output dll_calibration_request,
      input dll_calibration_acknowledge,
      input self_refresh_request,
      output self_refresh_acknowledge
   );
   modport partner (
      output test_mode_select, test_request_a, test_request_b,
      input test_acknowledge,
      input ext_bus_request,
      output ext_bus_grant, ext_bus_backoff,
      input dll_calibration_request,
      output dll_calibration_acknowledge,
      output self_refresh_request,
      input self_refresh_acknowledge
   );
endinterface

// ===== rtl/msc_partner.sv
// Purpose: Partner end: bus arbiter, tester port, DLL and power manager.
// Assumes: Same bus clock as the controller.
// Notes: User ports steer the tester, arbiter and power manager directly; the DLL answers on its own.
`timescale 1ns/1ps
`include "msc_consts.svh"
module msc_partner (
   // Clock, reset, enable
   input wire logic CLOCK,
   input wire logic RESET_N,
   input wire logic CLOCK_ENABLE,
   // Link
   msc_link_if.partner LINK,
   // User side
   input wire logic TEST_MODE,
   input wire logic VECTOR_VALID,
   input wire msc_pkg::msc_vec_t VECTOR_TYPE,
   input wire logic OTHER_WANTS_BUS,
   input wire logic REFRESH_WANTED,
   output logic VECTOR_DONE,
   output logic GRANTED,
   output logic REFRESH_ACTIVE,
   output logic CALIBRATION_DONE
);
   import msc_pkg::*;

   logic vec_sent;
   logic vec_low;

   // Tester: request entry with A, then hold each vector until acknowledge
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         LINK.test_mode_select <= 1'b0;
         LINK.test_request_a <= 1'b0;
         LINK.test_request_b <= 1'b0;
         vec_sent <= 1'b0;
         vec_low <= 1'b0;
         VECTOR_DONE <= 1'b0;
      end else if (CLOCK_ENABLE) begin
         LINK.test_mode_select <= TEST_MODE;
         VECTOR_DONE <= 1'b0;
         if (!TEST_MODE) begin
            {LINK.test_request_a, LINK.test_request_b} <= `MSC_VEC_IDLE;
            vec_sent <= 1'b0;
            vec_low <= 1'b0;
         end else if (!LINK.test_acknowledge) begin
            // Entry request, or the current vector held while low
            if (!vec_sent) begin
               LINK.test_request_a <= 1'b1;
            end else begin
               vec_low <= 1'b1;
            end
         end else if (vec_sent) begin
            // The access ends only when ack returns after its low phase
            if (vec_low) begin
               {LINK.test_request_a, LINK.test_request_b} <= `MSC_VEC_IDLE;
               vec_sent <= 1'b0;
               vec_low <= 1'b0;
               VECTOR_DONE <= 1'b1;
            end
         end else if (VECTOR_VALID &&
                      {LINK.test_request_a, LINK.test_request_b} == `MSC_VEC_IDLE) begin
            {LINK.test_request_a, LINK.test_request_b} <= VECTOR_TYPE;
            vec_sent <= (VECTOR_TYPE != `MSC_VEC_IDLE);
         end else begin
            {LINK.test_request_a, LINK.test_request_b} <= `MSC_VEC_IDLE;
         end
      end
   end

   // Arbiter: grant on request, back off when another controller wants it
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         LINK.ext_bus_grant <= 1'b0;
         LINK.ext_bus_backoff <= 1'b0;
         GRANTED <= 1'b0;
      end else if (CLOCK_ENABLE) begin
         if (!LINK.ext_bus_request) begin
            LINK.ext_bus_grant <= 1'b0;
            LINK.ext_bus_backoff <= 1'b0;
         end else if (!LINK.ext_bus_grant && !OTHER_WANTS_BUS) begin
            LINK.ext_bus_grant <= 1'b1;
         end else if (LINK.ext_bus_grant && OTHER_WANTS_BUS) begin
            LINK.ext_bus_backoff <= 1'b1;
         end
         GRANTED <= LINK.ext_bus_grant;
      end
   end

   // DLL: acknowledge follows the request, one cycle late
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         LINK.dll_calibration_acknowledge <= 1'b0;
         CALIBRATION_DONE <= 1'b0;
      end else if (CLOCK_ENABLE) begin
         LINK.dll_calibration_acknowledge <= LINK.dll_calibration_request;
         CALIBRATION_DONE <= LINK.dll_calibration_acknowledge &&
                             !LINK.dll_calibration_request;
      end
   end

   // Power manager: request held until acknowledge matches it
   always_ff @(posedge CLOCK or negedge RESET_N) begin
      if (!RESET_N) begin
         LINK.self_refresh_request <= 1'b0;
         REFRESH_ACTIVE <= 1'b0;
      end else if (CLOCK_ENABLE) begin
         if (LINK.self_refresh_request == LINK.self_refresh_acknowledge) begin
            LINK.self_refresh_request <= REFRESH_WANTED;
         end
         REFRESH_ACTIVE <= LINK.self_refresh_acknowledge;
      end
   end
endmodule

// ===== rtl/msc_pkg.sv
// Purpose: Types for the memory sideband control link.
// Assumes: Constants come from msc_consts.svh.
// Notes: One-hot state codes written out.
package msc_pkg;
   typedef logic [1:0] msc_vec_t;
   typedef enum logic [4:0] {
      MSC_IDLE = 5'h01,
      MSC_WAIT_GRANT = 5'h02,
      MSC_OWN = 5'h04,
      MSC_DRAIN = 5'h08,
      MSC_RELEASE = 5'h10
   } msc_bus_state_t;
endpackage

// ===== tb/memctl_sideband_control_tb.sv
// Purpose: Both link ends joined, driven from their user sides.
// Assumes: 25 MHz bus clock, inputs changed 1 ns after the edge.
// Notes: A second controller faces the bench, which drops grant early.
`timescale 1ns/1ps
module memctl_sideband_control_tb;
   import msc_pkg::*;
   // Clocks, resets, bookkeeping
   logic clock = 1'b0, clock_2x = 1'b0, clock_dly, reset_n = 1'b0, por_n = 1'b0;
   int n_fail = 0, cmp_count = 0, cycles = 0;
   msc_vec_t exp_q[$];
   msc_vec_t vec_sel = 2'h0, vec_type;
   logic access = 1'b0, access2 = 1'b0, calib = 1'b0, cmd_dly = 1'b1, ddr_en = 1'b1;
   logic test_mode = 1'b0, vec_valid = 1'b0, other = 1'b0, refresh = 1'b0, enable = 1'b1;
   logic [1:0] rd_pin = 2'h0, rd_save, ddr_cap;
   logic drive, in_test, in_sref, calibrated, vec_done, granted, refresh_act, drive2;
   logic launch, sdr_cap, cal_done;
   msc_link_if link ();
   msc_link_if link2 ();
   always #20 clock = ~clock;
   always #10 clock_2x = ~clock_2x;
   assign #5 clock_dly = clock;
   // Controller and partner facing each other
   msc_device msc_device_inst (.CLOCK(clock), .BUS_CLOCK_INVERTED(~clock),
      .DOUBLE_RATE_CLOCK(clock_2x), .DOUBLE_RATE_CLOCK_INVERTED(~clock_2x),
      .DELAYED_BUS_CLOCK(clock_dly), .RESET_N(reset_n), .POWER_ON_RESET_N(por_n),
      .CLOCK_ENABLE(enable), .LINK(link.device), .ACCESS_NEEDED(access),
      .CALIBRATE_START(calib), .COMMAND_DELAYED_MODE(cmd_dly), .DDR_ENABLE(ddr_en),
      .READ_DATA_PIN(rd_pin), .MEMORY_DRIVE(drive), .IN_TEST_MODE(in_test),
      .TEST_VECTOR_TYPE(vec_type), .IN_SELF_REFRESH(in_sref), .CALIBRATED(calibrated),
      .COMMAND_LAUNCH(launch), .DDR_CAPTURE(ddr_cap), .SDR_CAPTURE(sdr_cap));
   msc_partner msc_partner_inst (.CLOCK(clock), .RESET_N(reset_n), .CLOCK_ENABLE(enable),
      .LINK(link.partner), .TEST_MODE(test_mode), .VECTOR_VALID(vec_valid),
      .VECTOR_TYPE(vec_sel), .OTHER_WANTS_BUS(other), .REFRESH_WANTED(refresh),
      .VECTOR_DONE(vec_done), .GRANTED(granted), .REFRESH_ACTIVE(refresh_act),
      .CALIBRATION_DONE(cal_done));
   // Controller whose arbiter is the bench itself
   msc_device msc_device_inst_b (.CLOCK(clock), .BUS_CLOCK_INVERTED(~clock),
      .DOUBLE_RATE_CLOCK(clock_2x), .DOUBLE_RATE_CLOCK_INVERTED(~clock_2x),
      .DELAYED_BUS_CLOCK(clock_dly), .RESET_N(reset_n), .POWER_ON_RESET_N(por_n),
      .CLOCK_ENABLE(enable), .LINK(link2.device), .ACCESS_NEEDED(access2),
      .CALIBRATE_START(1'b0), .COMMAND_DELAYED_MODE(cmd_dly), .DDR_ENABLE(ddr_en),
      .READ_DATA_PIN(rd_pin), .MEMORY_DRIVE(drive2), .IN_TEST_MODE(),
      .TEST_VECTOR_TYPE(), .IN_SELF_REFRESH(), .CALIBRATED(), .COMMAND_LAUNCH(),
      .DDR_CAPTURE(), .SDR_CAPTURE());
   msc_link_properties msc_link_properties_inst (.CLOCK(clock), .RESET_N(reset_n),
      .test_mode_select(link.test_mode_select), .test_request_a(link.test_request_a),
      .test_request_b(link.test_request_b), .test_acknowledge(link.test_acknowledge),
      .ext_bus_request(link.ext_bus_request), .ext_bus_grant(link.ext_bus_grant),
      .ext_bus_backoff(link.ext_bus_backoff),
      .dll_calibration_request(link.dll_calibration_request),
      .dll_calibration_acknowledge(link.dll_calibration_acknowledge),
      .self_refresh_request(link.self_refresh_request),
      .self_refresh_acknowledge(link.self_refresh_acknowledge));
   task automatic chk(string what, logic [1:0] seen, logic [1:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Random read pins change with every step the bench takes
   task automatic tick(int n);
      repeat (n) @(posedge clock);
      #1;
      rd_pin = 2'($urandom);
   endtask
   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // Hang guard well above the sequence length
   always @(posedge clock) begin
      cycles++;
      if (cycles == 3000) begin
         n_fail++;
         end_of_test();
      end
   end
   // Finished vectors are matched against the oldest queued type
   always @(posedge clock) begin
      if (vec_done === 1'b1) begin
         chk("vector type", vec_type, exp_q.size() ? exp_q.pop_front() : 2'bxx);
      end
   end
   initial begin
      void'($urandom(65));
      link2.test_mode_select = 1'b0;
      link2.test_request_a = 1'b0;
      link2.test_request_b = 1'b0;
      link2.ext_bus_grant = 1'b0;
      link2.ext_bus_backoff = 1'b0;
      link2.dll_calibration_acknowledge = 1'b0;
      link2.self_refresh_request = 1'b0;
      tick(20);
      reset_n = 1'b1;
      access = 1'b1;
      tick(5);
      chk("ack after reset", link.test_acknowledge, 1'b0);
      chk("request before por", link.ext_bus_request, 1'b0);
      por_n = 1'b1;
      for (int i = 0; i < 30 && drive !== 1'b1; i++) tick(1);
      chk("request", link.ext_bus_request, 1'b1);
      chk("granted", {granted, drive}, 2'h3);
      other = 1'b1;
      for (int i = 0; i < 30 && drive !== 1'b0; i++) tick(1);
      chk("request after backoff", link.ext_bus_request, 1'b0);
      other = 1'b0;
      for (int i = 0; i < 30 && drive !== 1'b1; i++) tick(1);
      chk("regained bus", drive, 1'b1);
      tick(1);
      chk("command launch", launch, 1'b1);
      access = 1'b0;
      tick(8);
      refresh = 1'b1;
      for (int i = 0; i < 30 && refresh_act !== 1'b1; i++) tick(1);
      chk("self-refresh", {in_sref, link.self_refresh_acknowledge}, 2'h3);
      refresh = 1'b0;
      for (int i = 0; i < 30 && in_sref !== 1'b0; i++) tick(1);
      chk("self-refresh ack", link.self_refresh_acknowledge, 1'b0);
      calib = 1'b1;
      tick(1);
      calib = 1'b0;
      tick(1);
      chk("calibration request", link.dll_calibration_request, 1'b1);
      for (int i = 0; i < 30 && calibrated !== 1'b1; i++) tick(1);
      chk("calibration done", {calibrated, link.dll_calibration_request}, 2'h2);
      tick(1);
      chk("dll done pulse", cal_done, 1'b1);
      test_mode = 1'b1;
      for (int i = 0; i < 30 && in_test !== 1'b1; i++) tick(1);
      chk("test entry", {in_test, link.test_acknowledge}, 2'h3);
      // All three codes first, then random ones
      for (int v = 0; v < 7; v++) begin
         vec_sel = (v < 3) ? 2'(v + 1) : 2'($urandom_range(3, 1));
         exp_q.push_back(vec_sel);
         vec_valid = 1'b1;
         for (int i = 0; i < 30 && vec_done !== 1'b1; i++) tick(1);
         vec_valid = 1'b0;
         tick(3);
      end
      chk("vectors left", 2'(exp_q.size()), 2'h0);
      test_mode = 1'b0;
      for (int i = 0; i < 30 && in_test !== 1'b0; i++) tick(1);
      tick(1);
      chk("ack after exit", link.test_acknowledge, 1'b0);
      // Pins set after an edge show on the captures one bus cycle later
      for (int i = 0; i < 4; i++) begin
         rd_save = rd_pin;
         tick(1);
         chk("ddr capture", ddr_cap, rd_save);
         chk("sdr capture", sdr_cap, rd_save[0]);
      end
      // Bench arbiter withdraws grant without backoff
      access2 = 1'b1;
      for (int i = 0; i < 30 && link2.ext_bus_request !== 1'b1; i++) tick(1);
      link2.ext_bus_grant = 1'b1;
      for (int i = 0; i < 30 && drive2 !== 1'b1; i++) tick(1);
      chk("drive while granted", drive2, 1'b1);
      link2.ext_bus_grant = 1'b0;
      tick(4);
      chk("drive after grant loss", drive2, 1'b0);
      // Reset in mid-ownership clears the bus at once
      access = 1'b1;
      for (int i = 0; i < 30 && drive !== 1'b1; i++) tick(1);
      reset_n = 1'b0;
      #2;
      chk("drive in reset", {drive, link.ext_bus_request}, 2'h0);
      tick(2);
      reset_n = 1'b1;
      tick(2);
      end_of_test();
   end
endmodule

// ===== tb/msc_link_properties.sv
// Purpose: Protocol checks on the link wires between both ends.
// Assumes: One bus clock; reset active low and asynchronous.
// Notes: User-side effects are judged by the bench, not here.
`timescale 1ns/1ps
module msc_link_properties (
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RESET_N,
   // Link wires
   input wire logic test_mode_select,
   input wire logic test_request_a,
   input wire logic test_request_b,
   input wire logic test_acknowledge,
   input wire logic ext_bus_request,
   input wire logic ext_bus_grant,
   input wire logic ext_bus_backoff,
   input wire logic dll_calibration_request,
   input wire logic dll_calibration_acknowledge,
   input wire logic self_refresh_request,
   input wire logic self_refresh_acknowledge
);
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (!RESET_N);
   // Ack may only rise while test mode is selected
   property p_ack_sel; $rose(test_acknowledge) |-> $past(test_mode_select); endproperty
   a_ack_sel: assert property (p_ack_sel)
      else $error("ack rose outside test mode");
   // Each access holds ack low for exactly three cycles
   property p_ack_acc;
      $fell(test_acknowledge) && test_mode_select |-> !test_acknowledge [*3] ##1 test_acknowledge;
   endproperty
   a_ack_acc: assert property (p_ack_acc)
      else $error("access length wrong");
   // Ack is dropped one cycle after test mode leaves
   property p_ack_idle; !test_mode_select |=> !test_acknowledge; endproperty
   a_ack_idle: assert property (p_ack_idle)
      else $error("ack high outside test mode");
   // Tester holds its vector while ack stays low
   property p_vec_hold;
      test_mode_select && $past(test_mode_select) && !test_acknowledge
         && !$past(test_acknowledge) |-> $stable({test_request_a, test_request_b});
   endproperty
   a_vec_hold: assert property (p_vec_hold)
      else $error("vector changed while ack low");
   // Grant only answers a pending request
   property p_gnt_req; $rose(ext_bus_grant) |-> $past(ext_bus_request); endproperty
   a_gnt_req: assert property (p_gnt_req)
      else $error("grant without request");
   // Backoff empties the bus within the drain time
   property p_backoff;
      ext_bus_backoff && ext_bus_grant && ext_bus_request |-> ##[1:3] !ext_bus_request;
   endproperty
   a_backoff: assert property (p_backoff)
      else $error("bus kept after backoff");
   // Calibration request stands until acknowledged
   property p_dll_hold;
      dll_calibration_request && !dll_calibration_acknowledge |=> dll_calibration_request;
   endproperty
   a_dll_hold: assert property (p_dll_hold)
      else $error("calibration request dropped early");
   // Request is withdrawn soon after the acknowledge
   property p_dll_drop;
      $rose(dll_calibration_acknowledge) |-> ##[1:2] !dll_calibration_request;
   endproperty
   a_dll_drop: assert property (p_dll_drop)
      else $error("calibration request not withdrawn");
   // Self-refresh is acknowledged after entry with the bus idle
   property p_sref_on;
      $rose(self_refresh_request) && !ext_bus_request |-> ##[4:5] self_refresh_acknowledge;
   endproperty
   a_sref_on: assert property (p_sref_on)
      else $error("self-refresh ack late");
   // Four-phase: ack follows the request down
   property p_sref_off; !self_refresh_request |=> !self_refresh_acknowledge; endproperty
   a_sref_off: assert property (p_sref_off)
      else $error("self-refresh ack stuck");
endmodule
